// >>> ffl_flag_gen.sv
// word counter and status flag generation for a bus-matching fifo
module ffl_flag_gen
  import ffl_pkg::*;
#(
  parameter int           DEPTH18 = DEPTH18_DEF,
  parameter ffl_ofs_tbl_t DEF_OFS = OFS_TBL_DEF
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              arst_n,
  // master reset and straps sampled during it
  input  wire logic              master_reset_n,
  input  wire logic              flag_timing_select,
  input  wire logic              offset_load_select,
  input  wire logic              default_offset_select0,
  input  wire logic              default_offset_select1,
  input  wire logic              fall_through_mode,
  input  wire logic              input_width,
  input  wire logic              output_width,
  // word events from writer and reader
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  // status flags
  output logic                   full_flag_n,
  output logic                   empty_flag_n,
  output logic                   input_ready_n,
  output logic                   output_ready_n,
  output logic                   half_full_flag_n,
  output logic                   almost_full_flag_n,
  output logic                   almost_empty_flag_n,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   irq
);

  localparam int DMAX = 2 * DEPTH18;
  localparam int CW   = $clog2(DMAX + 2) + 1;
  localparam int OFW  = $clog2(DMAX);

  logic              mr;
  ffl_timing_e       timing_r;
  logic              serial_r;
  logic              fall_through_mode_r;
  logic              x9_r;
  logic [2:0]        ofs_code;
  logic [OFW-1:0]    def_ofs;
  logic [OFW-1:0]    eofs_r;
  logic [OFW-1:0]    fofs_r;
  logic [CW-1:0]     cnt_r;
  logic [CW-1:0]     cnt_nxt;
  logic [CW-1:0]     d_words;
  logic [CW-1:0]     cap;
  logic [CW-1:0]     th_hf;
  logic [CW-1:0]     th_af;
  logic [CW-1:0]     th_ae;
  logic              wr_ok;
  logic              rd_ok;
  logic              af_hit;
  logic              ae_low;
  logic              af_r;
  logic              af_nxt;
  logic              ae_r;
  logic              ae_nxt;
  logic              hf_r;
  logic              lvl_full_n;
  logic              lvl_empty_n;
  logic              lvl_ir_n;
  logic              lvl_or_n;
  logic              e_wr;
  logic              f_wr;
  logic              refuse;
  logic [ST_W-1:0]   ev;
  logic [ST_W-1:0]   status_r;
  logic [ST_W-1:0]   mask_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic              irq_r;
  logic [1:0]        settle_r;

  assign mr       = !master_reset_n;
  assign ofs_code = {offset_load_select, default_offset_select0,
                     default_offset_select1};
  assign def_ofs  = DEF_OFS[ofs_code][OFW-1:0];

  //////////////////////////////////////////////////////////////////////////
  // straps caught while master reset is held

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timing_r <= FFL_TIME_ASYNC;
      serial_r <= 1'b0;
      fall_through_mode_r   <= 1'b0;
      x9_r     <= 1'b0;
    end else if (mr) begin
      timing_r <= flag_timing_select ? FFL_TIME_SYNC
                                     : FFL_TIME_ASYNC;
      serial_r <= offset_load_select;
      fall_through_mode_r   <= fall_through_mode;
      x9_r     <= !input_width && !output_width;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // thresholds

  always_comb begin
    d_words = x9_r ? CW'(DMAX) : CW'(DEPTH18);
    cap     = d_words + (fall_through_mode_r ? CW'(FALL_THROUGH_MODE_EXTRA) : '0);
    th_hf   = (d_words >> 1)
            + (fall_through_mode_r ? CW'(HF_FALL_THROUGH_MODE) : CW'(HF_STD));
    th_af   = cap - CW'(fofs_r);
    th_ae   = CW'(eofs_r)
            + (fall_through_mode_r ? CW'(AE_FALL_THROUGH_MODE) : CW'(AE_STD));
  end

  //////////////////////////////////////////////////////////////////////////
  // word count; full and empty block the offending side

  assign wr_ok = wr_en && (cnt_r != cap);
  assign rd_ok = rd_en && (cnt_r != '0);

  always_comb begin
    cnt_nxt = cnt_r;
    if (wr_ok && !rd_ok) begin
      cnt_nxt = cnt_r + CW'(1);
    end else if (rd_ok && !wr_ok) begin
      cnt_nxt = cnt_r - CW'(1);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
    end else if (mr) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // programmable offsets

  assign e_wr   = reg_wr && (reg_addr == ADDR_EOFS) && !mr;
  assign f_wr   = reg_wr && (reg_addr == ADDR_FOFS) && !mr;
  // out-of-range writes are dropped and flagged, not clipped
  assign refuse = (e_wr || f_wr) && (reg_wdata >= DATA_W'(d_words));

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      eofs_r <= OFS_TBL_DEF[0][OFW-1:0];
      fofs_r <= OFS_TBL_DEF[0][OFW-1:0];
    end else if (mr) begin
      eofs_r <= def_ofs;
      fofs_r <= def_ofs;
    end else if (!refuse) begin
      if (e_wr) begin
        eofs_r <= reg_wdata[OFW-1:0];
      end
      if (f_wr) begin
        fofs_r <= reg_wdata[OFW-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // almost-full and almost-empty with selectable timing

  assign af_hit = cnt_nxt >= th_af;
  assign ae_low = cnt_nxt < th_ae;

  always_comb begin
    af_nxt = af_r;
    ae_nxt = ae_r;
    if (timing_r == FFL_TIME_SYNC) begin
      if (wr_en) begin
        af_nxt = !af_hit;
      end
      if (rd_en) begin
        ae_nxt = !ae_low;
      end
    end else begin
      if (wr_en && af_hit) begin
        af_nxt = 1'b0;
      end else if (rd_en && !af_hit) begin
        af_nxt = 1'b1;
      end
      if (rd_en && ae_low) begin
        ae_nxt = 1'b0;
      end else if (wr_en && !ae_low) begin
        ae_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      af_r <= 1'b1;
      ae_r <= 1'b0;
    end else if (mr) begin
      af_r <= 1'b1;
      ae_r <= 1'b0;
    end else begin
      af_r <= af_nxt;
      ae_r <= ae_nxt;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hf_r <= 1'b1;
    end else if (mr) begin
      hf_r <= 1'b1;
    end else begin
      hf_r <= cnt_nxt < th_hf;
    end
  end

  assign almost_full_flag_n  = af_r;
  assign almost_empty_flag_n = ae_r;
  assign half_full_flag_n    = hf_r;

  //////////////////////////////////////////////////////////////////////////
  // full/empty and ready flags through their register stages

  assign lvl_full_n  = cnt_r != cap;
  assign lvl_empty_n = cnt_r != '0;
  assign lvl_ir_n    = cnt_r == cap;
  assign lvl_or_n    = cnt_r == '0;

  ffl_stage_pipe #(.STAGES(FE_STAGES), .RST_VAL(1'b1)) u_full (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      (lvl_full_n),
    .q      (full_flag_n)
  );

  ffl_stage_pipe #(.STAGES(FE_STAGES), .RST_VAL(1'b0)) u_empty (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      (lvl_empty_n),
    .q      (empty_flag_n)
  );

  ffl_stage_pipe #(.STAGES(IR_STAGES), .RST_VAL(1'b0)) u_ir (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      (lvl_ir_n),
    .q      (input_ready_n)
  );

  ffl_stage_pipe #(.STAGES(OR_STAGES), .RST_VAL(1'b1)) u_or (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      (lvl_or_n),
    .q      (output_ready_n)
  );

  //////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and register reads

  always_comb begin
    ev            = '0;
    ev[ST_FULL]   = wr_ok && !rd_ok && (cnt_nxt == cap);
    ev[ST_EMPTY]  = rd_ok && !wr_ok && (cnt_nxt == '0);
    ev[ST_AF]     = af_r && !af_nxt && !mr;
    ev[ST_AE]     = ae_r && !ae_nxt && !mr;
    ev[ST_REFUSE] = refuse;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= '0;
    end else if (reg_wr && (reg_addr == ADDR_STATUS)) begin
      // a new event wins over a clear in the same cycle
      status_r <= (status_r & ~reg_wdata[ST_W-1:0]) | ev;
    end else begin
      status_r <= status_r | ev;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mask_r <= '0;
    end else if (reg_wr && (reg_addr == ADDR_MASK)) begin
      mask_r <= reg_wdata[ST_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & mask_r);
    end
  end

  always_comb begin
    rdata_nxt = '0;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_STATUS: rdata_nxt = DATA_W'(status_r);
        ADDR_MASK:   rdata_nxt = DATA_W'(mask_r);
        ADDR_COUNT:  rdata_nxt = DATA_W'(cnt_r);
        ADDR_EOFS:   rdata_nxt = DATA_W'(eofs_r);
        ADDR_FOFS:   rdata_nxt = DATA_W'(fofs_r);
        ADDR_CONFIG: begin
          rdata_nxt[CFG_SYNC]   = timing_r == FFL_TIME_SYNC;
          rdata_nxt[CFG_SERIAL] = serial_r;
          rdata_nxt[CFG_FALL_THROUGH_MODE]   = fall_through_mode_r;
          rdata_nxt[CFG_X9]     = x9_r;
        end
        default:     rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq       = irq_r;

  //////////////////////////////////////////////////////////////////////////
  // checks

  // pipelines hold reset values until they have refilled
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      settle_r <= '0;
    end else if (settle_r != 2'h3) begin
      settle_r <= settle_r + 2'h1;
    end
  end

  sequence s_af_wr_hit;
    wr_en && af_hit && !mr;
  endsequence

  sequence s_ae_rd_low;
    rd_en && ae_low && !mr;
  endsequence

  a_strap_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    !mr |=> $stable(timing_r))
    else $error("timing style changed outside master reset");

  a_af_sync_wr: assert property (@(posedge mclk) disable iff (!arst_n)
    (timing_r == FFL_TIME_SYNC && !wr_en && !mr)
      |=> $stable(almost_full_flag_n))
    else $error("sync almost-full moved without a write");

  a_ae_sync_rd: assert property (@(posedge mclk) disable iff (!arst_n)
    (timing_r == FFL_TIME_SYNC && !rd_en && !mr)
      |=> $stable(almost_empty_flag_n))
    else $error("sync almost-empty moved without a read");

  a_af_async_set: assert property (@(posedge mclk) disable iff (!arst_n)
    (timing_r == FFL_TIME_ASYNC) ##0 s_af_wr_hit |=> !almost_full_flag_n)
    else $error("async almost-full not set by write");

  a_af_async_rel: assert property (@(posedge mclk) disable iff (!arst_n)
    (timing_r == FFL_TIME_ASYNC && !$past(mr) && $rose(almost_full_flag_n))
      |-> $past(rd_en))
    else $error("async almost-full released without a read");

  a_ae_async_set: assert property (@(posedge mclk) disable iff (!arst_n)
    (timing_r == FFL_TIME_ASYNC) ##0 s_ae_rd_low |=> !almost_empty_flag_n)
    else $error("async almost-empty not set by read");

  a_ae_async_rel: assert property (@(posedge mclk) disable iff (!arst_n)
    (timing_r == FFL_TIME_ASYNC && !$past(mr) && $rose(almost_empty_flag_n))
      |-> $past(wr_en))
    else $error("async almost-empty released without a write");

  a_mr_defaults: assert property (@(posedge mclk) disable iff (!arst_n)
    mr |=> (eofs_r == $past(def_ofs)) && (fofs_r == $past(def_ofs))
           && (serial_r == $past(offset_load_select)))
    else $error("master reset offsets or load mode wrong");

  a_hf_level: assert property (@(posedge mclk) disable iff (!arst_n)
    (!mr && !$past(mr)) |-> (half_full_flag_n == (cnt_r < th_hf)))
    else $error("half-full level does not match count");

  a_no_overfill: assert property (@(posedge mclk) disable iff (!arst_n)
    cnt_r <= cap)
    else $error("word count above capacity");

  a_or_stages: assert property (@(posedge mclk) disable iff (!arst_n)
    (settle_r == 2'h3) |-> (output_ready_n == $past(lvl_or_n, 3)))
    else $error("output-ready not three stages behind count");

  a_ir_stages: assert property (@(posedge mclk) disable iff (!arst_n)
    (settle_r == 2'h3) |-> (input_ready_n == $past(lvl_ir_n, 2)))
    else $error("input-ready not two stages behind count");

  a_ofs_range: assert property (@(posedge mclk) disable iff (!arst_n)
    (e_wr && refuse) |=> $stable(eofs_r))
    else $error("out of range empty offset accepted");

endmodule // ffl_flag_gen

// >>> ffl_flag_gen_tb.sv
// self-checking bench for the fifo status flag generator
`define CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); \
  end \
end

module ffl_flag_gen_tb
  import ffl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic              mclk = 1'b0;
  logic              arst_n = 1'b0;
  logic              master_reset_n = 1'b1;
  logic              flag_timing_select = 1'b0;
  logic [2:0]        code = 3'h0;
  logic              fall_through_mode = 1'b0;
  logic              input_width = 1'b1;
  logic              output_width = 1'b1;
  logic              wr_en;
  logic              rd_en;
  logic              full_flag_n;
  logic              empty_flag_n;
  logic              input_ready_n;
  logic              output_ready_n;
  logic              half_full_flag_n;
  logic              almost_full_flag_n;
  logic              almost_empty_flag_n;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              irq;
  logic [DATA_W-1:0] v;
  int                mismatches = 0;
  int                check_count = 0;
  // default offsets indexed by {load, sel0, sel1}
  int                tbl[8] = '{127, 511, 255, 63, 31, 15, 7, 3};

  always #5 mclk = ~mclk;

  ffl_flag_gen u_dut (
    .mclk(mclk), .arst_n(arst_n), .master_reset_n(master_reset_n),
    .flag_timing_select(flag_timing_select),
    .offset_load_select(code[2]), .default_offset_select0(code[1]),
    .default_offset_select1(code[0]),
    .fall_through_mode(fall_through_mode),
    .input_width(input_width), .output_width(output_width),
    .wr_en(wr_en), .rd_en(rd_en),
    .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
    .input_ready_n(input_ready_n), .output_ready_n(output_ready_n),
    .half_full_flag_n(half_full_flag_n),
    .almost_full_flag_n(almost_full_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
  );

  ffl_word_src u_src (.mclk(mclk), .wr_en(wr_en), .rd_en(rd_en));

  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wreg(input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    // one idle edge so a following write never re-raises the strobe
    // in the same time step that lowered it
    @(posedge mclk);
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rreg(input logic [ADDR_W-1:0] a,
                      output logic [DATA_W-1:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge mclk);
  endtask

  task automatic chk_reg(input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] d;
    rreg(a, d);
    `CHK(d, e)
  endtask

  // straps are captured on every edge while master reset is low
  task automatic mrst(input logic [2:0] c, input logic s, ft, iw, ow);
    master_reset_n <= 1'b0;
    code <= c;
    flag_timing_select <= s;
    fall_through_mode <= ft;
    input_width <= iw;
    output_width <= ow;
    repeat (2) @(posedge mclk);
    master_reset_n <= 1'b1;
    @(posedge mclk);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic chk_flags(input int c, d, n, m);
    logic [4:0] e;
    logic [4:0] g;
    int         k;
    k = fall_through_mode ? 1 : 0;
    e[4] = (c == d + k) ~^ fall_through_mode;
    e[3] = (c == 0) ~^ fall_through_mode;
    e[2] = c < d / 2 + 1 + k;
    e[1] = c < d + k - m;
    e[0] = c >= n + 1 + k;
    g = {fall_through_mode ? {input_ready_n, output_ready_n}
                           : {full_flag_n, empty_flag_n},
         half_full_flag_n, almost_full_flag_n, almost_empty_flag_n};
    `CHK(g, e)
  endtask

  // fill one past capacity, then drain one past empty
  task automatic sweep(input int d, n, m);
    int                cap;
    logic [DATA_W-1:0] r;
    cap = d + (fall_through_mode ? 1 : 0);
    wreg(ADDR_EOFS, DATA_W'(n));
    wreg(ADDR_FOFS, DATA_W'(m));
    for (int c = 1; c <= cap + 1; c++) begin
      u_src.burst(1'b1, 1'b0, 1, 3);
      #1 chk_flags(c > cap ? cap : c, d, n, m);
      @(posedge mclk);
    end
    rreg(ADDR_COUNT, r);
    `CHK(r, DATA_W'(cap))
    for (int c = cap - 1; c >= -1; c--) begin
      u_src.burst(1'b0, 1'b1, 1, 3);
      #1 chk_flags(c < 0 ? 0 : c, d, n, m);
      @(posedge mclk);
    end
  endtask

  // first word: empty or output-ready changes only after its stages
  task automatic first_word();
    int lag;
    lag = fall_through_mode ? OR_STAGES : FE_STAGES;
    u_src.burst(1'b1, 1'b0, 1, 0);
    for (int i = 1; i <= lag; i++) begin
      @(posedge mclk);
      #1 `CHK(fall_through_mode ? !output_ready_n : empty_flag_n, i == lag)
    end
    @(posedge mclk);
    u_src.burst(1'b0, 1'b1, 1, 4);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      mrst(3'(i), 1'b0, 1'b0, i[0], i[1]);
      chk_reg(ADDR_EOFS, DATA_W'(tbl[i]));
      chk_reg(ADDR_FOFS, DATA_W'(tbl[i]));
      rreg(ADDR_CONFIG, v);
      `CHK({v[CFG_SERIAL], v[CFG_X9]}, {i[2], ~(i[0] | i[1])})
    end
    // offset range and refusal interrupt
    mrst(3'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    wreg(ADDR_STATUS, '1);
    wreg(ADDR_MASK, '0);
    wreg(ADDR_EOFS, DATA_W'(DEPTH18_DEF));
    chk_reg(ADDR_EOFS, DATA_W'(127));
    wreg(ADDR_FOFS, DATA_W'(DEPTH18_DEF - 1));
    chk_reg(ADDR_FOFS, DATA_W'(DEPTH18_DEF - 1));
    rreg(ADDR_STATUS, v);
    `CHK({v[ST_REFUSE], irq}, 2'b10)
    wreg(ADDR_MASK, DATA_W'(1) << ST_REFUSE);
    @(posedge mclk);
    #1 `CHK(irq, 1'b1)
    @(posedge mclk);
    wreg(ADDR_STATUS, DATA_W'(1) << ST_REFUSE);
    @(posedge mclk);
    #1 `CHK(irq, 1'b0)
    @(posedge mclk);
    chk_reg(5'h1c, '0);
    // sync timing: almost flags move only on their own side's events
    mrst(3'h7, 1'b1, 1'b0, 1'b1, 1'b1);
    wreg(ADDR_CONFIG, '0);
    chk_reg(ADDR_CONFIG, DATA_W'(3));
    u_src.burst(1'b1, 1'b0, 5, 0);
    #1 `CHK(almost_empty_flag_n, 1'b0)
    @(posedge mclk);
    u_src.burst(1'b1, 1'b1, 1, 0);
    #1 `CHK(almost_empty_flag_n, 1'b1)
    @(posedge mclk);
    u_src.burst(1'b1, 1'b0, 505, 0);
    @(posedge mclk);
    u_src.burst(1'b0, 1'b1, 2, 0);
    #1 `CHK(almost_full_flag_n, 1'b0)
    @(posedge mclk);
    u_src.burst(1'b1, 1'b1, 1, 0);
    #1 `CHK(almost_full_flag_n, 1'b1)
    @(posedge mclk);
    // async level sweeps: standard, fall-through, nine-bit depth
    mrst(3'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    first_word();
    sweep(DEPTH18_DEF, 5, 6);
    mrst(3'h0, 1'b0, 1'b1, 1'b1, 1'b0);
    first_word();
    sweep(DEPTH18_DEF, 5, 6);
    mrst(3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    sweep(2 * DEPTH18_DEF, 9, 2);
    end_of_test();
  end
endmodule // ffl_flag_gen_tb

// >>> ffl_pkg.sv
// shared constants for the fifo status flag generator
package ffl_pkg;

  // default 18-bit word depth of the smallest variant
  localparam int DEPTH18_DEF = 512;

  // register port
  localparam int          ADDR_W      = 5;
  localparam int          DATA_W      = 32;
  localparam logic [4:0]  ADDR_STATUS = 5'h00;
  localparam logic [4:0]  ADDR_MASK   = 5'h04;
  localparam logic [4:0]  ADDR_COUNT  = 5'h08;
  localparam logic [4:0]  ADDR_EOFS   = 5'h0c;
  localparam logic [4:0]  ADDR_FOFS   = 5'h10;
  localparam logic [4:0]  ADDR_CONFIG = 5'h14;

  // status and mask bit positions
  localparam int ST_FULL   = 0;
  localparam int ST_EMPTY  = 1;
  localparam int ST_AF     = 2;
  localparam int ST_AE     = 3;
  localparam int ST_REFUSE = 4;
  localparam int ST_W      = 5;

  // config readback bit positions
  localparam int CFG_SYNC   = 0;
  localparam int CFG_SERIAL = 1;
  localparam int CFG_FALL_THROUGH_MODE   = 2;
  localparam int CFG_X9     = 3;

  // flag pipeline depths
  localparam int FE_STAGES = 2;
  localparam int IR_STAGES = 2;
  localparam int OR_STAGES = 3;

  // threshold margins: standard vs fall-through
  localparam int FALL_THROUGH_MODE_EXTRA = 1;
  localparam int HF_STD     = 1;
  localparam int HF_FALL_THROUGH_MODE    = 2;
  localparam int AE_STD     = 1;
  localparam int AE_FALL_THROUGH_MODE    = 2;

  // default offset table, index {load_sel, sel0, sel1}
  typedef logic [7:0][15:0] ffl_ofs_tbl_t;
  localparam ffl_ofs_tbl_t OFS_TBL_DEF = {
    16'h0003, 16'h0007, 16'h000f, 16'h001f,
    16'h003f, 16'h00ff, 16'h01ff, 16'h007f
  };

  typedef enum logic {FFL_TIME_ASYNC, FFL_TIME_SYNC} ffl_timing_e;

endpackage

// >>> ffl_stage_pipe.sv
// register chain that delays a flag by a fixed number of stages
module ffl_stage_pipe #(
  parameter int   STAGES  = 2,
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // flag in and out
  input  wire logic d,
  output logic      q
);

  logic [STAGES-1:0] stg_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stg_r <= {STAGES{RST_VAL}};
    end else begin
      stg_r <= {stg_r[STAGES-2:0], d};
    end
  end

  assign q = stg_r[STAGES-1];

endmodule // ffl_stage_pipe

// >>> ffl_word_src.sv
// writer and reader model driving word events into the flag generator
module ffl_word_src (
  // clock
  input  wire logic mclk,
  // word events
  output logic      wr_en,
  output logic      rd_en
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // call right after a rising edge; strobes held for k events in a row,
  // then released for gap cycles to model a slow writer or reader
  task automatic burst(input logic w, input logic r, input int k,
                       input int gap);
    wr_en <= w;
    rd_en <= r;
    repeat (k) @(posedge mclk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (gap) @(posedge mclk);
  endtask
endmodule // ffl_word_src
